// >>> src/group_stagger.sv
/*
 * Delays channel group g (1..3) by g stagger steps relative to group 0.
 * Assumes raw enables come from flops on i_clk.
 */
module group_stagger (
    input wire logic i_clk,
    input wire logic i_reset,
    stagger_if.stage sif
);
    import led_pwm_pkg::*;

    // ----------------------------------------
    // delay line, one tap per stagger cycle
    // ----------------------------------------
    localparam int TAPS = (GROUPS - 1) * STAGGER_CYCLES;
    logic [15:0] line [TAPS:1];
    logic [15:0] tap_out [GROUPS];

    // tap 0 is the undelayed input, kept apart from the flops so each has one driver
    always_comb begin
        tap_out[0] = sif.raw_on;
        for (int g = 1; g < GROUPS; g++) begin
            tap_out[g] = line[g * STAGGER_CYCLES];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int t = 1; t <= TAPS; t++) begin
                line[t] <= 16'h0000;
            end
        end else begin
            line[1] <= sif.raw_on;
            for (int t = 2; t <= TAPS; t++) begin
                line[t] <= line[t - 1];
            end
        end
    end

    // groups of four switch together; group g takes tap g*step unless bypassed
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            sif.staggered_on[g*GROUP_SIZE +: GROUP_SIZE] = sif.bypass ?
                sif.raw_on[g*GROUP_SIZE +: GROUP_SIZE] :
                tap_out[g][g*GROUP_SIZE +: GROUP_SIZE];
        end
    end

    group_aligned_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !sif.bypass |-> sif.staggered_on[7:4] == $past(sif.raw_on[7:4], 3))
        else $error("group 1 not one stagger step late");
endmodule : group_stagger

// >>> src/led_greyscale_pwm.sv
/*
 * Sixteen-channel greyscale pwm engine with serial data input, grey level
 * and current trim latches, and 192-bit status readback on serial_out.
 * Assumes all controller pins are asynchronous to i_clk and slow enough
 * (link clocks near 8 MHz) to be sampled after two flops.
 */
// Function
// - status readback loads only while mode is low (greyscale).
// - latch in greyscale mode overwrites shift register with status packet.
// - status packet is 192 bits, presented on serial_out.
// - open-led flags in bits 191:176 and duplicated in 31:16.
// - thermal error flag sits in packet bit 175.
// - all sixteen trim values in bits 167:72, channel 15 msb first.
// - shorted-led flags in bits 15:0, despite the reserved marking.
// - unassigned packet bits are reserved and read as zero.
// - blank falling edge starts a new pwm cycle.
// - first count pulse increments counter, turns on nonzero channels.
// - each later count clock rising edge increments the counter until it reaches 4096.
// - channel switches off when its grey level equals the counter.
// - blank high after 4096 pulses resets counter, completing the cycle.
// - channels switch in fixed groups of four consecutive outputs.
// - nominal 25ns stagger between groups, option to disable it; code rounds up to 3 clocks of 10ns, so groups step 30ns apart.
// - blank high disables all outputs and holds counter reset.
// - latch rising edge loads grey levels (mode low) or trims (mode high).
// - power-up: grey 4095, trim 63, greyscale mode, shift registers clear.
module led_greyscale_pwm (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_output_blank,
    input wire logic i_pwm_count_clock,
    input wire logic i_shift_clock,
    input wire logic i_serial_in,
    input wire logic i_latch_strobe,
    input wire logic i_mode,
    input wire logic i_thermal_error_flag,
    input wire logic i_thermal_warning_flag,
    input wire logic [led_pwm_pkg::CHANNELS-1:0] i_open_led_flags,
    input wire logic [led_pwm_pkg::CHANNELS-1:0] i_short_led_flags,
    input wire logic i_stagger_disable,
    output logic o_serial_out,
    output logic [led_pwm_pkg::CHANNELS-1:0] o_sink_channel,
    output logic [12:0] o_grey_counter
);
    import led_pwm_pkg::*;

    // ----------------------------------------
    // input synchronisers and edge detection
    // ----------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] pins;
    assign pins = {i_mode, i_latch_strobe, i_shift_clock, i_pwm_count_clock, i_output_blank};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1 <= 5'h01;
            sync2 <= 5'h01;
            sync3 <= 5'h01;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic sin1;
    logic sin2;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sin1 <= 1'b0;
            sin2 <= 1'b0;
        end else begin
            sin1 <= i_serial_in;
            sin2 <= sin1;
        end
    end

    // detector flags come from another domain; bit 33 error, 32 warning,
    // 31:16 open, 15:0 shorted
    logic [33:0] flag_s1;
    logic [33:0] flag_s2;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            flag_s1 <= '0;
            flag_s2 <= '0;
        end else begin
            flag_s1 <= {i_thermal_error_flag, i_thermal_warning_flag,
                        i_open_led_flags, i_short_led_flags};
            flag_s2 <= flag_s1;
        end
    end

    logic blank;
    logic blank_fall;
    logic count_rise;
    logic shift_rise;
    logic latch_rise;
    logic mode;
    assign blank = sync2[0];
    assign blank_fall = sync3[0] && !sync2[0];
    assign count_rise = !sync3[1] && sync2[1];
    assign shift_rise = !sync3[2] && sync2[2];
    assign latch_rise = !sync3[3] && sync2[3];
    assign mode = sync2[4];

    // ----------------------------------------
    // shift register and status packet
    // ----------------------------------------
    logic [PACKET_W-1:0] shift_reg;
    logic [GREY_W-1:0] grey_level [CHANNELS];
    logic [TRIM_W-1:0] current_trim [CHANNELS];
    logic [PACKET_W-1:0] status_packet;

    always_comb begin
        status_packet = '0;
        status_packet[OPEN_HI_LSB +: CHANNELS] = flag_s2[31:16];
        status_packet[OPEN_LO_LSB +: CHANNELS] = flag_s2[31:16];
        status_packet[THERMAL_ERR_BIT] = flag_s2[33];
        status_packet[THERMAL_WARN_BIT] = flag_s2[32];
        for (int c = 0; c < CHANNELS; c++) begin
            status_packet[TRIM_LSB + c*TRIM_W +: TRIM_W] = current_trim[c];
        end
        status_packet[SHORT_LSB +: CHANNELS] = flag_s2[15:0];
    end

    // in trim mode only the low 96 bits form the input register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            shift_reg <= '0;
        end else if (latch_rise && !mode) begin
            shift_reg <= status_packet;
        end else if (shift_rise) begin
            shift_reg <= {shift_reg[PACKET_W-2:0], sin2};
        end
    end

    // trim mode reads out at the 96-bit boundary so cascades see the right length
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_serial_out <= 1'b0;
        end else if (mode) begin
            o_serial_out <= shift_reg[TRIM_PACKET_W-1];
        end else begin
            o_serial_out <= shift_reg[PACKET_W-1];
        end
    end

    // ----------------------------------------
    // latches for grey levels and trims
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                grey_level[c] <= GREY_RESET;
            end
        end else if (latch_rise && !mode) begin
            for (int c = 0; c < CHANNELS; c++) begin
                grey_level[c] <= shift_reg[c*GREY_W +: GREY_W];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int c = 0; c < CHANNELS; c++) begin
                current_trim[c] <= TRIM_RESET;
            end
        end else if (latch_rise && mode) begin
            for (int c = 0; c < CHANNELS; c++) begin
                current_trim[c] <= shift_reg[c*TRIM_W +: TRIM_W];
            end
        end
    end

    // ----------------------------------------
    // greyscale counter and channel compare
    // ----------------------------------------
    // counter saturates at 4096 so a late blank does not wrap and relight
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_grey_counter <= 13'h0000;
        end else if (blank || blank_fall) begin
            o_grey_counter <= 13'h0000;
        end else if (count_rise && o_grey_counter != CYCLE_COUNTS) begin
            o_grey_counter <= o_grey_counter + 13'h0001;
        end
    end

    logic [CHANNELS-1:0] raw_on;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            raw_on <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (blank || blank_fall) begin
                    raw_on[c] <= 1'b0;
                end else if (count_rise && o_grey_counter == 13'h0000) begin
                    raw_on[c] <= grey_level[c] != 12'h000;
                end else if ({1'b0, grey_level[c]} == o_grey_counter) begin
                    raw_on[c] <= 1'b0;
                end
            end
        end
    end

    stagger_if sif ();
    assign sif.raw_on = raw_on;
    assign sif.bypass = i_stagger_disable;

    group_stagger u_stagger (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .sif(sif)
    );

    // blank gates the pins directly so no stagger tail leaks past it
    assign o_sink_channel = blank ? '0 : sif.staggered_on;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence latch_grey_s;
        latch_rise && !mode;
    endsequence

    blank_dark_a: assert property (@(posedge i_clk) disable iff (i_reset)
        blank |-> o_sink_channel == '0 ##1 o_grey_counter == 13'h0000)
        else $error("outputs lit during blank");
    status_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
        latch_grey_s |=> shift_reg[THERMAL_ERR_BIT] == $past(flag_s2[33]))
        else $error("status packet not loaded");
    open_copies_a: assert property (@(posedge i_clk) disable iff (i_reset)
        latch_grey_s |=> shift_reg[191:176] == shift_reg[31:16])
        else $error("open flag copies differ");
    trim_no_load_a: assert property (@(posedge i_clk) disable iff (i_reset)
        latch_rise && mode && !shift_rise |=> $stable(shift_reg))
        else $error("status loaded in trim mode");
    count_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
        count_rise && !blank && !blank_fall && o_grey_counter < CYCLE_COUNTS |=>
        o_grey_counter == $past(o_grey_counter) + 13'h0001)
        else $error("counter did not step");
    first_on_a: assert property (@(posedge i_clk) disable iff (i_reset)
        count_rise && !blank && !blank_fall && o_grey_counter == 13'h0000 &&
        grey_level[0] != 12'h000 |=> raw_on[0])
        else $error("channel 0 not switched on");
    match_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !count_rise && o_grey_counter != 13'h0000 &&
        {1'b0, grey_level[5]} == o_grey_counter |=> !raw_on[5])
        else $error("channel 5 not switched off at match");
    fall_restart_a: assert property (@(posedge i_clk) disable iff (i_reset)
        blank_fall |=> o_grey_counter == 13'h0000 && raw_on == '0)
        else $error("cycle not restarted");
    msb_first_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !mode ##1 !mode |-> o_serial_out == $past(shift_reg[PACKET_W-1]))
        else $error("serial out not msb");
endmodule : led_greyscale_pwm

// >>> src/led_pwm_pkg.sv
/*
 * Package for the greyscale pwm and status readback block: widths, packet
 * field positions, power-up values and output stagger timing.
 * Assumes a single 100 MHz system clock.
 */
package led_pwm_pkg;
    localparam int CHANNELS = 16;
    localparam int GREY_W = 12;
    localparam int TRIM_W = 6;
    localparam int PACKET_W = 192;
    localparam int TRIM_PACKET_W = 96;
    localparam int GROUP_SIZE = 4;
    localparam int GROUPS = 4;
    // packet field positions
    localparam int OPEN_HI_LSB = 176;
    localparam int THERMAL_ERR_BIT = 175;
    localparam int THERMAL_WARN_BIT = 174;
    localparam int TRIM_LSB = 72;
    localparam int OPEN_LO_LSB = 16;
    localparam int SHORT_LSB = 0;
    // power-up values and pwm cycle length
    localparam logic [11:0] GREY_RESET = 12'hFFF;
    localparam logic [5:0] TRIM_RESET = 6'h3F;
    localparam logic [12:0] CYCLE_COUNTS = 13'h1000;
    // stagger between channel groups
    localparam int CLK_PERIOD_NS = 10;
    localparam int STAGGER_NS = 25;
    localparam int STAGGER_CYCLES = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : led_pwm_pkg

// >>> src/stagger_if.sv
/*
 * Carries the undelayed channel enables from the pwm core to the stagger
 * stage, and the staggered sink outputs back.
 * Assumes both ends share i_clk.
 */
interface stagger_if;
    logic [15:0] raw_on;
    logic bypass;
    logic [15:0] staggered_on;
    modport core (output raw_on, output bypass, input staggered_on);
    modport stage (input raw_on, input bypass, output staggered_on);
endinterface : stagger_if

// >>> testbench/led_ctl_model.sv
/*
 * Display controller model: drives blank, count clock, shift clock, serial
 * data and latch pins, and reads serial_out back while shifting.
 * Assumes the caller sequences frames; pins are asynchronous to i_clk.
 */
module led_ctl_model (
    output logic o_output_blank,
    output logic o_pwm_count_clock,
    output logic o_shift_clock,
    output logic o_serial_in,
    output logic o_latch_strobe,
    input wire logic i_serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_output_blank = 1'b1;
        o_pwm_count_clock = 1'b0;
        o_shift_clock = 1'b0;
        o_serial_in = 1'b1;
        o_latch_strobe = 1'b0;
    end
    // shift clock stands still outside frames; read bit sampled before each rise
    task automatic shift(input logic [191:0] d, input int n, output logic [191:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--) begin
            o_serial_in = d[i];
            #62.5;
            q[i] = i_serial_out;
            o_shift_clock = 1'b1;
            #62.5;
            o_shift_clock = 1'b0;
        end
        // released data line shows the inverse so a stale bit cannot pass
        o_serial_in = ~o_serial_in;
    endtask : shift
    task automatic latch();
        #125 o_latch_strobe = 1'b1;
        #125 o_latch_strobe = 1'b0;
        #125;
    endtask : latch
    task automatic pulse();
        o_pwm_count_clock = 1'b1;
        #40 o_pwm_count_clock = 1'b0;
        #40;
    endtask : pulse
    task automatic blank(input logic b);
        o_output_blank = b;
        #100;
    endtask : blank
endmodule : led_ctl_model

// >>> testbench/tb_led_greyscale_pwm.sv
/*
 * Self-checking bench for the greyscale pwm and status readback block.
 * Assumes the controller model drives every link pin except mode, which the bench sets.
 */
module tb_led_greyscale_pwm import led_pwm_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_mode = 1'b0;
    logic terr = 1'b0;
    logic twarn = 1'b0;
    logic stag_dis = 1'b0;
    logic [15:0] open_f = '0;
    logic [15:0] short_f = '0;
    wire logic blank, pcc, sck, sdi, serial_out, ld;
    wire logic [15:0] sink;
    wire logic [12:0] cnt;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 54;
    logic [191:0] grey, q;
    logic [95:0] trims;
    always #5 i_clk = ~i_clk;
    led_ctl_model led_ctl_model_inst (.o_output_blank(blank), .o_pwm_count_clock(pcc),
        .o_shift_clock(sck), .o_serial_in(sdi), .o_latch_strobe(ld), .i_serial_out(serial_out));
    led_greyscale_pwm led_greyscale_pwm_inst (.i_clk(i_clk), .i_reset(i_reset),
        .i_output_blank(blank), .i_pwm_count_clock(pcc), .i_shift_clock(sck),
        .i_serial_in(sdi), .i_latch_strobe(ld),
        .i_mode(i_mode), .i_thermal_error_flag(terr), .i_thermal_warning_flag(twarn),
        .i_open_led_flags(open_f), .i_short_led_flags(short_f),
        .i_stagger_disable(stag_dis), .o_serial_out(serial_out), .o_sink_channel(sink),
        .o_grey_counter(cnt));
    // ----------------------------------------
    // checking and expectations
    // ----------------------------------------
    task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    function automatic logic [191:0] status(input logic [95:0] t);
        return {open_f, terr, twarn, 6'h00, t, 40'h0, open_f, short_f};
    endfunction : status
    function automatic logic [15:0] sinks_at(input int k);
        for (int c = 0; c < 16; c++)
            sinks_at[c] = grey[c*12 +: 12] != 0 && k < grey[c*12 +: 12];
    endfunction : sinks_at
    // one pulse after a blank fall, then the first rise cycle of each sink
    task automatic meas(input logic dis);
        int rise [16];
        @(posedge i_clk) #1 stag_dis = dis;
        foreach (rise[j]) rise[j] = -1;
        led_ctl_model_inst.blank(1'b0);
        fork
            led_ctl_model_inst.pulse();
        join_none
        for (int c = 0; c < 40; c++) begin
            @(posedge i_clk) #1;
            foreach (rise[j]) if (sink[j] === 1'b1 && rise[j] < 0) rise[j] = c;
        end
        foreach (rise[j]) chk(rise[j], rise[0] + (dis ? 0 : STAGGER_CYCLES * (j / GROUP_SIZE)));
        chk(cnt, 1);
        chk(sink, 16'hFFFF);
        led_ctl_model_inst.blank(1'b1);
        repeat (6) @(posedge i_clk);
        #1;
        chk(sink, 0);
        chk(cnt, 0);
    endtask : meas
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_reset = 1'b0;
        repeat (4) @(posedge i_clk);
        chk({serial_out, sink, cnt}, 0);
        meas(1'b0);
        meas(1'b1);
        $display("test stagger done");
        for (int c = 0; c < 16; c++) grey[c*12 +: 12] = 12'($random(seed));
        grey[47:0] = {12'h800, 12'hFFF, 12'h001, 12'h000};
        for (int c = 0; c < 16; c++) trims[c*6 +: 6] = 6'($random(seed));
        led_ctl_model_inst.shift(grey, 192, q);
        chk(q, 0);
        led_ctl_model_inst.latch();
        @(posedge i_clk) #1 i_mode = 1'b1;
        repeat (4) @(posedge i_clk);
        led_ctl_model_inst.shift(trims, 96, q);
        chk(q, status({16{TRIM_RESET}}) & {96'h0, {96{1'b1}}});
        led_ctl_model_inst.latch();
        led_ctl_model_inst.shift(~trims, 96, q);
        chk(q, trims);
        @(posedge i_clk) #1 i_mode = 1'b0;
        open_f = 16'($random(seed));
        short_f = 16'($random(seed));
        terr = 1'($random(seed));
        twarn = 1'($random(seed));
        repeat (4) @(posedge i_clk);
        led_ctl_model_inst.shift(grey, 192, q);
        led_ctl_model_inst.latch();
        led_ctl_model_inst.shift(grey, 192, q);
        chk(q, status(trims));
        $display("test readback done");
        @(posedge i_clk) #1 stag_dis = 1'b1;
        led_ctl_model_inst.blank(1'b0);
        for (int k = 1; k <= 4100; k++) begin
            led_ctl_model_inst.pulse();
            chk(cnt, k > 4096 ? 4096 : k);
            chk(sink, sinks_at(k));
        end
        led_ctl_model_inst.blank(1'b1);
        repeat (6) @(posedge i_clk);
        chk({sink, cnt}, 0);
        $display("test pwm cycle done");
        close_out();
    end
    initial begin
        #900us;
        n_mismatch++;
        close_out();
    end
endmodule : tb_led_greyscale_pwm
